// ==== design/tim_consts.vh ====
// Named constants for the instruction timing sequencer.
// Assumes inclusion by bare name from the design files; holds definitions only.
`ifndef TIM_CONSTS_VH
`define TIM_CONSTS_VH

// Width of the cycle count fields and of the remaining-cycle counter.
`define TIM_CYC_W 4
// Width of the instruction length field in bytes.
`define TIM_LEN_W 2

// Execution times in system clock cycles.
`define TIM_CYC0 4'h0
`define TIM_CYC1 4'h1
`define TIM_CYC2 4'h2
`define TIM_CYC3 4'h3
`define TIM_CYC4 4'h4
`define TIM_CYC5 4'h5
`define TIM_CYC8 4'h8

// Longest execution time any instruction may take.
`define TIM_MAX_CYCLES 4'h8
// Extra cycle spent by a conditional branch that is taken.
`define TIM_BRANCH_EXTRA 4'h1

// Instruction lengths in bytes.
`define TIM_LEN0 2'h0
`define TIM_LEN1 2'h1
`define TIM_LEN2 2'h2
`define TIM_LEN3 2'h3

// Reset value of the retired-instruction counter.
`define TIM_COUNT_RESET 16'h0000

// Highest core clock the timing holds for, and the rate this build runs at, in MHz.
`define TIM_CORE_MAX_MHZ 50
`define TIM_CLK_MHZ 125

`endif

// ==== design/tim_cycle_counter.v ====
// Remaining-cycle down counter for the instruction timing sequencer.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
`include "tim_consts.vh"

module tim_cycle_counter #(
	parameter WIDTH = `TIM_CYC_W
) (
	input wire clk,
	input wire reset,
	input wire load,
	input wire [WIDTH-1:0] loadValue,
	output reg [WIDTH-1:0] count_r
);

	// Zero at the counter's width, so the compare never pads.
	localparam [WIDTH-1:0] ZERO = {WIDTH{1'b0}};
	// One at the counter's width for the decrement.
	localparam [WIDTH-1:0] ONE = {{(WIDTH-1){1'b0}}, 1'b1};

	// Next value of the count.
	reg [WIDTH-1:0] count_nxt;

	// A load wins over the decrement; otherwise count down to zero and rest there.
	always @* begin
		count_nxt = count_r;
		if (load) begin
			count_nxt = loadValue;
		end else if (count_r != ZERO) begin
			count_nxt = count_r - ONE;
		end
	end

	// State register; reset leaves no cycles pending.
	always @(posedge clk) begin
		if (reset) begin
			count_r <= ZERO;
		end else begin
			count_r <= count_nxt;
		end
	end

endmodule // tim_cycle_counter

// ==== design/tim_instr_timing.v ====
// Instruction timing sequencer of the pipelined 8-bit core: decodes each opcode
// into its length in bytes and its execution time in clock cycles, and paces issue.
// Assumes the fetch stage presents one opcode at a time with its branch outcome,
// and that program and data memory answer within the cycles given here.
//
// Function
// - Count execution time in plain clock cycles.
// - Most instructions: cycles equal byte count.
// - Untaken conditional branch finishes one cycle sooner.
// - No instruction exceeds eight clock cycles.
// - Classic opcode encoding; only timing differs.
// - 109 instructions in classes 1 to 8.
// - Add, add-carry, subtract-borrow register: one byte, one cycle.
// - Arithmetic through indirect pointer: one byte, two cycles.
// - Arithmetic immediate into accumulator: two bytes, two cycles.
// - Arithmetic direct byte into accumulator: two bytes, two.
// - AND/OR immediate into direct byte: three bytes, three.
// - Logic accumulator into direct byte: two bytes, two.
// - Logic through indirect pointer: one byte, two cycles.
// - Correct from zero to 50 MHz, single-cycle instructions at one per clock.
`timescale 1ns/100ps
`include "tim_consts.vh"

module tim_instr_timing #(
	parameter COUNT_W = 16
) (
	input wire clk,
	input wire reset,
	input wire instrValid,
	input wire [7:0] opcode,
	input wire branchTaken,
	output reg instrReady_r,
	output reg busy_r,
	output reg operandFetch_r,
	output reg retireValid_r,
	output reg [`TIM_LEN_W-1:0] retireBytes_r,
	output reg [`TIM_CYC_W-1:0] retireCycles_r,
	output reg retireTaken_r,
	output reg retireReserved_r,
	output reg [COUNT_W-1:0] retiredCount_r
);

	// The timing holds for the documented clock range; a faster build clock only
	// shortens wall time, the cycle counts stay the same.
	localparam CLK_OK = (`TIM_CLK_MHZ > 0);

	// High nibble selects the row of the opcode map, low nibble the column.
	wire [3:0] opHi;
	wire [3:0] opLo;
	assign opHi = opcode[7:4];
	assign opLo = opcode[3:0];

	// Decoded length, base time, conditional flag and reserved-opcode flag.
	reg [`TIM_LEN_W-1:0] dLen;
	reg [`TIM_CYC_W-1:0] dCyc;
	reg dCond;
	reg dRsvd;

	// Opcode decode over the classic encoding. The column picks the addressing mode
	// (register, indirect pointer, direct, immediate) and the row picks the operation.
	always @* begin
		dLen = `TIM_LEN1;
		dCyc = `TIM_CYC1;
		dCond = 1'b0;
		dRsvd = 1'b0;
		case (opLo)
		4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'hf: begin
			// Bank register columns.
			case (opHi)
			4'h7, 4'h8, 4'ha: begin
				// Moves with a direct or immediate byte.
				dLen = `TIM_LEN2;
				dCyc = `TIM_CYC2;
			end
			4'hb: begin
				// Compare with immediate and jump.
				dLen = `TIM_LEN3;
				dCyc = `TIM_CYC3;
				dCond = 1'b1;
			end
			4'hd: begin
				// Decrement register and jump if not zero.
				dLen = `TIM_LEN2;
				dCyc = `TIM_CYC2;
				dCond = 1'b1;
			end
			default: begin
				// Add, add-with-carry, subtract-with-borrow, logic, increment and moves.
				dLen = `TIM_LEN1;
				dCyc = `TIM_CYC1;
			end
			endcase
		end
		4'h6, 4'h7: begin
			// Indirect pointer register columns.
			case (opHi)
			4'h7, 4'h8, 4'ha: begin
				dLen = `TIM_LEN2;
				dCyc = `TIM_CYC2;
			end
			4'hb: begin
				dLen = `TIM_LEN3;
				dCyc = `TIM_CYC3;
				dCond = 1'b1;
			end
			default: begin
				// One byte but a memory read through the pointer costs a second cycle.
				dLen = `TIM_LEN1;
				dCyc = `TIM_CYC2;
			end
			endcase
		end
		4'h5: begin
			// Direct byte column.
			case (opHi)
			4'h7, 4'h8: begin
				dLen = `TIM_LEN3;
				dCyc = `TIM_CYC3;
			end
			4'ha: begin
				// Unused opcode; it is retired as a one-cycle no-operation.
				dRsvd = 1'b1;
			end
			4'hb: begin
				// Compare direct byte with accumulator: the one 4/5 case.
				dLen = `TIM_LEN3;
				dCyc = `TIM_CYC4;
				dCond = 1'b1;
			end
			4'hd: begin
				dLen = `TIM_LEN3;
				dCyc = `TIM_CYC3;
				dCond = 1'b1;
			end
			default: begin
				dLen = `TIM_LEN2;
				dCyc = `TIM_CYC2;
			end
			endcase
		end
		4'h4: begin
			// Accumulator-only and immediate column.
			case (opHi)
			4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9: begin
				dLen = `TIM_LEN2;
				dCyc = `TIM_CYC2;
			end
			4'h8: begin
				// Divide is the slowest instruction.
				dCyc = `TIM_CYC8;
			end
			4'ha: begin
				dCyc = `TIM_CYC4;
			end
			4'hb: begin
				dLen = `TIM_LEN3;
				dCyc = `TIM_CYC3;
				dCond = 1'b1;
			end
			default: begin
				// Increment, decrement, swap, decimal adjust, clear, complement.
				dCyc = `TIM_CYC1;
			end
			endcase
		end
		4'h3: begin
			case (opHi)
			4'h4, 4'h5, 4'h6: begin
				// Logic immediate into a direct byte.
				dLen = `TIM_LEN3;
				dCyc = `TIM_CYC3;
			end
			4'h7, 4'h8, 4'h9, 4'he, 4'hf: begin
				// Code reads, indirect jump and external data moves.
				dCyc = `TIM_CYC3;
			end
			default: begin
				// Rotates, data pointer increment, carry operations.
				dCyc = `TIM_CYC1;
			end
			endcase
		end
		4'h2: begin
			case (opHi)
			4'h0, 4'h1: begin
				// Long jump and long call.
				dLen = `TIM_LEN3;
				dCyc = `TIM_CYC4;
			end
			4'h2, 4'h3: begin
				// Returns.
				dCyc = `TIM_CYC5;
			end
			4'he, 4'hf: begin
				dCyc = `TIM_CYC3;
			end
			default: begin
				// Logic from the accumulator into a direct byte, and bit operations.
				dLen = `TIM_LEN2;
				dCyc = `TIM_CYC2;
			end
			endcase
		end
		4'h1: begin
			// Absolute jump and call share this column across all rows.
			dLen = `TIM_LEN2;
			dCyc = `TIM_CYC3;
		end
		default: begin
			// Column zero: no-operation, bit and flag branches, short jump, moves.
			case (opHi)
			4'h0: begin
				dCyc = `TIM_CYC1;
			end
			4'h1, 4'h2, 4'h3: begin
				dLen = `TIM_LEN3;
				dCyc = `TIM_CYC3;
				dCond = 1'b1;
			end
			4'h4, 4'h5, 4'h6, 4'h7: begin
				dLen = `TIM_LEN2;
				dCyc = `TIM_CYC2;
				dCond = 1'b1;
			end
			4'h8: begin
				dLen = `TIM_LEN2;
				dCyc = `TIM_CYC3;
			end
			4'h9: begin
				dLen = `TIM_LEN3;
				dCyc = `TIM_CYC3;
			end
			4'he, 4'hf: begin
				dCyc = `TIM_CYC3;
			end
			default: begin
				dLen = `TIM_LEN2;
				dCyc = `TIM_CYC2;
			end
			endcase
		end
		endcase
	end

	// Remaining cycles of the instruction in flight, counted in plain clocks.
	wire [`TIM_CYC_W-1:0] remain;

	// An issue is taken when the fetch stage offers and the sequencer is ready.
	wire accept;
	assign accept = instrValid & instrReady_r;

	// The branch outcome only matters for conditional opcodes.
	wire takenNow;
	assign takenNow = dCond & branchTaken;

	// Total time of the offered instruction, held to the longest allowed.
	reg [`TIM_CYC_W-1:0] cycTot;

	// A taken branch pays one extra cycle; the untaken form finishes at the base time.
	always @* begin
		cycTot = dCyc;
		if (takenNow) begin
			cycTot = dCyc + `TIM_BRANCH_EXTRA;
		end
		if (cycTot > `TIM_MAX_CYCLES) begin
			cycTot = `TIM_MAX_CYCLES;
		end
	end

	// Cycles still owed after the issue cycle itself.
	wire [`TIM_CYC_W-1:0] loadValue;
	assign loadValue = cycTot - `TIM_CYC1;

	// The counter is loaded at issue and counts one per clock down to zero.
	tim_cycle_counter #(
		.WIDTH(`TIM_CYC_W)
	) uCounter (
		.clk(clk),
		.reset(reset),
		.load(accept),
		.loadValue(loadValue),
		.count_r(remain)
	);

	// Operand bytes still to fetch for the instruction in flight.
	reg [`TIM_LEN_W-1:0] opLeft_r;
	reg [`TIM_LEN_W-1:0] opLeft_nxt;
	// Details of the multi-cycle instruction in flight, reported when it retires.
	reg [`TIM_LEN_W-1:0] curLen_r;
	reg [`TIM_CYC_W-1:0] curCyc_r;
	reg curTaken_r;
	reg curRsvd_r;

	// Next values of the outputs.
	reg instrReady_nxt;
	reg retireValid_nxt;
	reg operandFetch_nxt;

	// Issue pacing: ready again once the last owed cycle is in progress, so
	// single-cycle instructions issue back to back at one per clock.
	always @* begin
		if (accept) begin
			instrReady_nxt = (cycTot == `TIM_CYC1);
			retireValid_nxt = (cycTot == `TIM_CYC1);
		end else begin
			instrReady_nxt = (remain <= `TIM_CYC1);
			retireValid_nxt = (remain == `TIM_CYC1);
		end
	end

	// Operand fetch: one byte per cycle after the opcode, so byte count sets the
	// floor of the execution time.
	always @* begin
		opLeft_nxt = opLeft_r;
		operandFetch_nxt = 1'b0;
		if (accept) begin
			opLeft_nxt = dLen - `TIM_LEN1;
			operandFetch_nxt = (dLen > `TIM_LEN1);
		end else if (opLeft_r != `TIM_LEN0) begin
			opLeft_nxt = opLeft_r - `TIM_LEN1;
			operandFetch_nxt = (opLeft_r > `TIM_LEN1);
		end
	end

	// Sequencer registers. A one-cycle instruction retires straight from the
	// decode; a longer one retires from the held copy.
	always @(posedge clk) begin
		if (reset) begin
			instrReady_r <= 1'b1;
			busy_r <= 1'b0;
			operandFetch_r <= 1'b0;
			retireValid_r <= 1'b0;
			retireBytes_r <= `TIM_LEN0;
			retireCycles_r <= `TIM_CYC0;
			retireTaken_r <= 1'b0;
			retireReserved_r <= 1'b0;
			retiredCount_r <= `TIM_COUNT_RESET;
			opLeft_r <= `TIM_LEN0;
			curLen_r <= `TIM_LEN0;
			curCyc_r <= `TIM_CYC0;
			curTaken_r <= 1'b0;
			curRsvd_r <= 1'b0;
		end else begin
			instrReady_r <= instrReady_nxt;
			busy_r <= ~instrReady_nxt;
			operandFetch_r <= operandFetch_nxt;
			retireValid_r <= retireValid_nxt;
			opLeft_r <= opLeft_nxt;
			if (accept) begin
				curLen_r <= dLen;
				curCyc_r <= cycTot;
				curTaken_r <= takenNow;
				curRsvd_r <= dRsvd;
			end
			if (accept && cycTot == `TIM_CYC1) begin
				retireBytes_r <= dLen;
				retireCycles_r <= cycTot;
				retireTaken_r <= takenNow;
				retireReserved_r <= dRsvd;
			end else if (retireValid_nxt) begin
				retireBytes_r <= curLen_r;
				retireCycles_r <= curCyc_r;
				retireTaken_r <= curTaken_r;
				retireReserved_r <= curRsvd_r;
			end
			// The count wraps silently; below the wrap it tallies every retirement exactly.
			if (retireValid_nxt && CLK_OK) begin
				retiredCount_r <= retiredCount_r + {{(COUNT_W-1){1'b0}}, 1'b1};
			end
		end
	end

endmodule // tim_instr_timing

// ==== tb/tim_instr_timing_checker.sv ====
// Concurrent checks on the ports of the instruction timing sequencer.
// Assumes one clock and a synchronous active-high reset; bound below the module.
`timescale 1ns/100ps
module tim_instr_timing_checker #(
	parameter COUNT_W = 16
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic instrValid,
	input wire logic [7:0] opcode,
	input wire logic branchTaken,
	input wire logic instrReady_r,
	input wire logic busy_r,
	input wire logic operandFetch_r,
	input wire logic retireValid_r,
	input wire logic [1:0] retireBytes_r,
	input wire logic [3:0] retireCycles_r,
	input wire logic retireTaken_r,
	input wire logic retireReserved_r,
	input wire logic [COUNT_W-1:0] retiredCount_r
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	// An opcode is taken at this edge.
	sequence s_issue(op);
		instrValid && instrReady_r && opcode == op;
	endsequence
	// A short conditional jump is taken at this edge with a given outcome.
	sequence s_cond(tk);
		instrValid && instrReady_r && opcode == 8'h40 && branchTaken == tk;
	endsequence
	property p_busy; busy_r == !instrReady_r; endproperty
	property p_max; retireValid_r |-> retireCycles_r != 4'h0 && retireCycles_r <= 4'h8; endproperty
	// The retire counter moves only with a retirement, so a stuck counter shows.
	// The edge that follows a reset cycle is skipped, since the count was cleared there, not stepped.
	property p_count;
		!$past(reset) |-> retiredCount_r == $past(retiredCount_r) + COUNT_W'(retireValid_r);
	endproperty
	property p_reg;
		s_issue(8'h28) |=> retireValid_r && instrReady_r && retireBytes_r == 2'h1 && retireCycles_r == 4'h1;
	endproperty
	property p_ind;
		s_issue(8'h26) |=> !instrReady_r ##1 (retireValid_r && retireBytes_r == 2'h1 && retireCycles_r == 4'h2);
	endproperty
	property p_fetch;
		s_issue(8'h53) |=> operandFetch_r [*2] ##1 (!operandFetch_r && retireValid_r && retireBytes_r == 2'h3);
	endproperty
	property p_taken;
		s_cond(1'b1) |=> !instrReady_r [*2] ##1 (retireValid_r && retireTaken_r && retireCycles_r == 4'h3);
	endproperty
	property p_untaken;
		s_cond(1'b0) |=> !instrReady_r ##1 (retireValid_r && !retireTaken_r && retireCycles_r == 4'h2);
	endproperty
	property p_div; s_issue(8'h84) |=> !instrReady_r [*7] ##1 (instrReady_r && retireCycles_r == 4'h8); endproperty
	property p_res; s_issue(8'ha5) |=> retireValid_r && retireReserved_r; endproperty
	a_busy: assert property (p_busy) else $error("busy is not the inverse of ready");
	a_max: assert property (p_max) else $error("retired cycle count out of range");
	a_count: assert property (p_count) else $error("retire counter mismatch");
	a_reg: assert property (p_reg) else $error("register add timing wrong");
	a_ind: assert property (p_ind) else $error("indirect add timing wrong");
	a_fetch: assert property (p_fetch) else $error("operand fetch pulses wrong");
	a_taken: assert property (p_taken) else $error("taken branch timing wrong");
	a_untaken: assert property (p_untaken) else $error("untaken branch timing wrong");
	a_div: assert property (p_div) else $error("divide timing wrong");
	a_res: assert property (p_res) else $error("unused opcode not flagged");
endmodule // tim_instr_timing_checker

bind tim_instr_timing tim_instr_timing_checker #(.COUNT_W(COUNT_W)) u_chk (.clk(clk), .reset(reset),
	.instrValid(instrValid), .opcode(opcode), .branchTaken(branchTaken), .instrReady_r(instrReady_r),
	.busy_r(busy_r), .operandFetch_r(operandFetch_r), .retireValid_r(retireValid_r),
	.retireBytes_r(retireBytes_r), .retireCycles_r(retireCycles_r), .retireTaken_r(retireTaken_r),
	.retireReserved_r(retireReserved_r), .retiredCount_r(retiredCount_r));

// ==== tb/tim_fetch_model.sv ====
// Fetch stage model that offers one opcode at a time to the sequencer.
// Assumes the bench holds offer until offerAck is seen high at a rising edge.
`timescale 1ns/100ps
module tim_fetch_model (
	input wire logic clk,
	input wire logic reset,
	input wire logic instrReady,
	input wire logic offer,
	input wire logic [7:0] offerOp,
	input wire logic offerTaken,
	output logic instrValid,
	output logic [7:0] opcode,
	output logic branchTaken,
	output wire logic offerAck
);
	// A new opcode fits when the slot is empty or is being taken this edge.
	assign offerAck = offer && !reset && (!instrValid || instrReady);
	// The offer is held until taken, since refused offers are simply ignored.
	always @(posedge clk) begin
		if (reset) begin
			instrValid <= 1'b0;
		end else if (offerAck) begin
			instrValid <= 1'b1;
			opcode <= offerOp;
			branchTaken <= offerTaken;
		end else if (instrValid && instrReady) begin
			// Released lines show the inverse so stale values never look valid.
			instrValid <= 1'b0;
			opcode <= ~opcode;
			branchTaken <= ~branchTaken;
		end
	end
endmodule // tim_fetch_model

// ==== tb/tb_cpu_instruction_timing.sv ====
// Self-checking bench for the instruction timing sequencer.
// Assumes the fetch model in front of it and the bound checker beside it.
`timescale 1ns/100ps
module tb_cpu_instruction_timing;
	logic clk = 1'b0, reset = 1'b1, offer = 1'b0, offerTaken = 1'b0;
	logic [7:0] offerOp = 8'h00;
	wire logic instrValid, branchTaken, offerAck, ready, retV, retT, retR;
	wire logic [7:0] opcode;
	wire logic [1:0] retB;
	wire logic [3:0] retC;
	wire logic [15:0] retCnt;
	int n_errors = 0, num_checks = 0, cyc = 0, issued = 0;
	logic [7:0] qe[$];
	int qc[$];
	logic [31:0] st = 32'h58;
	// Table of opcodes covering every timing class but two bytes in three cycles, including long jump, return and the 4/5 compare.
	logic [7:0] ops[26] = '{8'h28, 8'h38, 8'h98, 8'h04, 8'h14, 8'ha3, 8'ha5, 8'h26, 8'h56, 8'h46, 8'h66,
		8'h24, 8'h25, 8'h52, 8'h53, 8'h43, 8'h75, 8'ha4, 8'h84, 8'h40, 8'h20, 8'h02, 8'h22, 8'h73,
		8'hb5, 8'hd8};
	tim_fetch_model u_fetch (.clk(clk), .reset(reset), .instrReady(ready), .offer(offer), .offerOp(offerOp),
		.offerTaken(offerTaken), .instrValid(instrValid), .opcode(opcode), .branchTaken(branchTaken),
		.offerAck(offerAck));
	tim_instr_timing #(.COUNT_W(16)) dut (.clk(clk), .reset(reset), .instrValid(instrValid), .opcode(opcode),
		.branchTaken(branchTaken), .instrReady_r(ready), .busy_r(), .operandFetch_r(), .retireValid_r(retV),
		.retireBytes_r(retB), .retireCycles_r(retC), .retireTaken_r(retT), .retireReserved_r(retR),
		.retiredCount_r(retCnt));
	// Half period of 4 ns gives the 125 MHz clock.
	always #4 clk = ~clk;
	// Expected {reserved, taken, bytes, cycles}; a taken conditional adds one cycle.
	function automatic logic [7:0] expv(input logic [7:0] op, input logic tk);
		case (op)
			8'ha5: expv = 8'h91;
			8'h26, 8'h56, 8'h46, 8'h66: expv = 8'h12;
			8'h24, 8'h25, 8'h52: expv = 8'h22;
			8'h53, 8'h43, 8'h75: expv = 8'h33;
			8'ha4: expv = 8'h14;
			8'h84: expv = 8'h18;
			8'h40, 8'hd8: expv = tk ? 8'h63 : 8'h22;
			8'h20: expv = tk ? 8'h74 : 8'h33;
			8'hb5: expv = tk ? 8'h75 : 8'h34;
			8'h02: expv = 8'h34;
			8'h22: expv = 8'h15;
			8'h73: expv = 8'h13;
			default: expv = 8'h11;
		endcase
	endfunction
	// Xorshift keeps the random stream repeatable from its fixed start.
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		xs = s ^ (s << 5);
	endfunction
	task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	// Offer stays raised after the hand-over so back-to-back offers need no gap.
	task automatic send(input logic [7:0] op, input logic tk);
		offer <= 1'b1;
		offerOp <= op;
		offerTaken <= tk;
		do @(posedge clk); while (offerAck !== 1'b1);
	endtask
	task automatic idle(input int n);
		offer <= 1'b0;
		repeat (n) @(posedge clk);
	endtask
	task tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Monitor pairs each retirement with its issue edge and measures the latency.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc > 20000) begin
			n_errors++;
			tally_and_finish;
		end else if (reset) begin
			qe.delete();
			qc.delete();
			issued <= 0;
		end else begin
			if (retV === 1'b1) begin
				if (qe.size() == 0)
					check(16'h1, 16'h0, "retire without issue");
				else begin
					check({8'h0, retR, retT, retB, retC}, {8'h0, qe[0]}, "retire fields");
					check(16'(cyc - qc[0]), {12'h0, qe[0][3:0]}, "latency");
					void'(qe.pop_front());
					void'(qc.pop_front());
				end
			end
			if (instrValid === 1'b1 && ready === 1'b1) begin
				qe.push_back(expv(opcode, branchTaken));
				qc.push_back(cyc);
				issued <= issued + 1;
			end
		end
	end
	task automatic reset_check();
		#1;
		check({15'h0, ready}, 16'h1, "ready after reset");
		check(retCnt, 16'h0, "count after reset");
	endtask
	initial begin
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		reset_check();
		for (int i = 0; i < 26; i++)
			send(ops[i], 1'b0);
		send(8'h40, 1'b1);
		send(8'h20, 1'b1);
		send(8'hb5, 1'b1);
		send(8'hd8, 1'b1);
		idle(12);
		$display("test table done");
		for (int i = 0; i < 300; i++) begin
			st = xs(st);
			send(ops[st[12:8] % 26], st[3]);
			if (st[1:0] != 2'b00)
				idle(int'(st[1:0]));
		end
		idle(12);
		check(retCnt, 16'(issued), "retired count");
		$display("test random done");
		send(8'h84, 1'b0);
		idle(3);
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		reset_check();
		send(8'h28, 1'b0);
		idle(3);
		check(retCnt, 16'h1, "count after abort");
		$display("test abort done");
		tally_and_finish;
	end
endmodule // tb_cpu_instruction_timing
